/* File: inc/dac_status_pkg.sv */
// Package for the converter output view and underrun status block
// Contract
// - Channel 2 output word readable at bits 11:0 of offset 0x30, read-only.
// - Channel 2 underrun flag at status bit 29, write one clears.
// - Channel 2 underrun event from trigger-faster-than-DMA sets its flag.
// - Channel 1 underrun flag at status bit 13, write one clears.
// - Channel 1 underrun event from trigger-faster-than-DMA sets its flag.
// - Channel 1 output word readable at bits 11:0 of offset 0x2C, read-only.
package dac_status_pkg;
	localparam int         ADDR_W         = 8;
	localparam int         DATA_W         = 32;
	localparam int         WORD_W         = 12;
	localparam logic [7:0] OFS_CH1_OUTPUT = 8'h2C;
	localparam logic [7:0] OFS_CH2_OUTPUT = 8'h30;
	localparam logic [7:0] OFS_STATUS     = 8'h34;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h38;
	localparam int         BIT_CH1_UDR    = 13;
	localparam int         BIT_CH2_UDR    = 29;
	localparam logic [31:0] RST_STATUS    = 32'h0000_0000;
	localparam logic [31:0] RST_MASK      = 32'h0000_0000;
	localparam logic [31:0] RST_OUTPUT    = 32'h0000_0000;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic ch2;
		logic ch1;
	} udr_pair_t;
endpackage

/* File: design/udr_flag.sv */
`timescale 1ns/1ps
// One sticky underrun flag: hardware set, write-one clear, set wins
module udr_flag (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Set and clear
	input  wire logic setEvt,
	input  wire logic clrReq,
	// Flag
	output logic      flag
);
	logic flag_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else if (setEvt) begin
			flag_ff <= 1'b1;
		end else if (clrReq) begin
			flag_ff <= 1'b0;
		end
	end

	assign flag = flag_ff;

	property p_set_wins;
		@(posedge clk) disable iff (!rst_n) setEvt |=> flag_ff;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("underrun event lost");

	c_set_and_clear: cover property (@(posedge clk) disable iff (!rst_n) setEvt && clrReq);
endmodule

/* File: design/dac_output_status.sv */
`timescale 1ns/1ps
// Output word views and underrun status registers of a two-channel converter
module dac_output_status #(
	parameter int WORD_W = dac_status_pkg::WORD_W
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Register port
	input  wire dac_status_pkg::bus_req_t  busReq,
	output logic [31:0]                    rdData,
	// Converter side
	input  wire logic [WORD_W-1:0]         ch1OutputWord,
	input  wire logic [WORD_W-1:0]         ch2OutputWord,
	input  wire dac_status_pkg::udr_pair_t udrEvt,
	// Interrupt
	output logic                           irq
);
	logic [31:0] rdData_ff;
	logic [31:0] nxt_rdData;
	logic [1:0]  mask_ff;
	logic        irq_ff;
	logic        ch1UnderrunFlag;
	logic        ch2UnderrunFlag;
	logic        wrStatus;
	logic        clr1;
	logic        clr2;

	// The word must fit within a 32-bit register, from 1 up to all 32 bits
	if (WORD_W < 1 || WORD_W > 32) begin : g_word_w_check
		$error("output word width must lie between 1 and 32");
	end

	// Reserved bits above the word always read zero
	function automatic logic [31:0] widen_word(input logic [WORD_W-1:0] w);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[WORD_W-1:0] = w;
		return v;
	endfunction

	assign wrStatus = busReq.wr && (busReq.addr == dac_status_pkg::OFS_STATUS);
	// Writing zero leaves a flag alone
	assign clr1 = wrStatus && busReq.wdata[dac_status_pkg::BIT_CH1_UDR];
	assign clr2 = wrStatus && busReq.wdata[dac_status_pkg::BIT_CH2_UDR];

	udr_flag u_ch1 (
		.clk    (clk),
		.rst_n  (rst_n),
		.setEvt (udrEvt.ch1),
		.clrReq (clr1),
		.flag   (ch1UnderrunFlag)
	);

	udr_flag u_ch2 (
		.clk    (clk),
		.rst_n  (rst_n),
		.setEvt (udrEvt.ch2),
		.clrReq (clr2),
		.flag   (ch2UnderrunFlag)
	);

	function automatic logic [31:0] pack_status(input logic f1, input logic f2);
		logic [31:0] v;
		v = dac_status_pkg::RST_STATUS;
		v[dac_status_pkg::BIT_CH1_UDR] = f1;
		v[dac_status_pkg::BIT_CH2_UDR] = f2;
		return v;
	endfunction

	// Mask shares the status layout; only the two flag bits are held
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_ff <= 2'b00;
		end else if (busReq.wr && busReq.addr == dac_status_pkg::OFS_IRQ_MASK) begin
			mask_ff <= {busReq.wdata[dac_status_pkg::BIT_CH2_UDR],
				busReq.wdata[dac_status_pkg::BIT_CH1_UDR]};
		end
	end

	always_comb begin
		nxt_rdData = 32'h0000_0000;
		case (busReq.addr)
			dac_status_pkg::OFS_CH1_OUTPUT: nxt_rdData = widen_word(ch1OutputWord);
			dac_status_pkg::OFS_CH2_OUTPUT: nxt_rdData = widen_word(ch2OutputWord);
			dac_status_pkg::OFS_STATUS:
				nxt_rdData = pack_status(ch1UnderrunFlag, ch2UnderrunFlag);
			dac_status_pkg::OFS_IRQ_MASK: nxt_rdData = pack_status(mask_ff[0], mask_ff[1]);
			default: nxt_rdData = 32'h0000_0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdData_ff <= 32'h0000_0000;
		end else if (busReq.rd) begin
			rdData_ff <= nxt_rdData;
		end else begin
			rdData_ff <= 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |({ch2UnderrunFlag, ch1UnderrunFlag} & mask_ff);
		end
	end

	assign rdData = rdData_ff;
	assign irq    = irq_ff;

	property p_ch2_set;
		@(posedge clk) disable iff (!rst_n) udrEvt.ch2 |=> ch2UnderrunFlag;
	endproperty
	a_ch2_set: assert property (p_ch2_set) else $error("ch2 flag not set");

	property p_ch1_set;
		@(posedge clk) disable iff (!rst_n) udrEvt.ch1 |=> ch1UnderrunFlag;
	endproperty
	a_ch1_set: assert property (p_ch1_set) else $error("ch1 flag not set");

	property p_ch2_clear;
		@(posedge clk) disable iff (!rst_n) clr2 && !udrEvt.ch2 |=> !ch2UnderrunFlag;
	endproperty
	a_ch2_clear: assert property (p_ch2_clear) else $error("ch2 clear failed");

	property p_ch1_clear;
		@(posedge clk) disable iff (!rst_n) clr1 && !udrEvt.ch1 |=> !ch1UnderrunFlag;
	endproperty
	a_ch1_clear: assert property (p_ch1_clear) else $error("ch1 clear failed");

	property p_ch2_read;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr == dac_status_pkg::OFS_CH2_OUTPUT
		|=> rdData[WORD_W-1:0] == $past(ch2OutputWord) && (rdData >> WORD_W) == 32'h0000_0000;
	endproperty
	a_ch2_read: assert property (p_ch2_read) else $error("ch2 word read wrong");

	property p_ch1_read;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr == dac_status_pkg::OFS_CH1_OUTPUT
		|=> rdData[WORD_W-1:0] == $past(ch1OutputWord) && (rdData >> WORD_W) == 32'h0000_0000;
	endproperty
	a_ch1_read: assert property (p_ch1_read) else $error("ch1 word read wrong");

	property p_status_rsvd;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr == dac_status_pkg::OFS_STATUS
		|=> (rdData & 32'hDFFF_DFFF) == 32'h0000_0000;
	endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("reserved bits set");

	property p_zero_write;
		@(posedge clk) disable iff (!rst_n)
		wrStatus && !busReq.wdata[dac_status_pkg::BIT_CH2_UDR] && ch2UnderrunFlag
		|=> ch2UnderrunFlag;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared");

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		ch1UnderrunFlag && mask_ff[0] |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	property p_irq2;
		@(posedge clk) disable iff (!rst_n)
		ch2UnderrunFlag && mask_ff[1]
		|=> irq;
	endproperty
	a_irq2: assert property (p_irq2) else $error("irq missing for ch2");

	property p_irq_low;
		@(posedge clk) disable iff (!rst_n)
		!(ch1UnderrunFlag && mask_ff[0]) && !(ch2UnderrunFlag && mask_ff[1])
		|=> !irq;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq without unmasked flag");

	// Read port behaviour
	property p_idle_rd;
		@(posedge clk) disable iff (!rst_n)
		!busReq.rd
		|=> rdData == 32'h0000_0000;
	endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("read data outside read cycle");

	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr != dac_status_pkg::OFS_CH1_OUTPUT
		&& busReq.addr != dac_status_pkg::OFS_CH2_OUTPUT
		&& busReq.addr != dac_status_pkg::OFS_STATUS
		&& busReq.addr != dac_status_pkg::OFS_IRQ_MASK
		|=> rdData == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_status_read;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr == dac_status_pkg::OFS_STATUS
		|=> rdData[dac_status_pkg::BIT_CH2_UDR] == $past(ch2UnderrunFlag)
		&& rdData[dac_status_pkg::BIT_CH1_UDR] == $past(ch1UnderrunFlag);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_mask_read;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr == dac_status_pkg::OFS_IRQ_MASK
		|=> rdData[dac_status_pkg::BIT_CH2_UDR] == $past(mask_ff[1])
		&& rdData[dac_status_pkg::BIT_CH1_UDR] == $past(mask_ff[0]);
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

	property p_mask_rsvd;
		@(posedge clk) disable iff (!rst_n)
		busReq.rd && busReq.addr == dac_status_pkg::OFS_IRQ_MASK
		|=> (rdData & 32'hDFFF_DFFF) == 32'h0000_0000;
	endproperty
	a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask reserved bits set");

	// Mask register
	property p_mask_write;
		@(posedge clk) disable iff (!rst_n)
		busReq.wr && busReq.addr == dac_status_pkg::OFS_IRQ_MASK
		|=> mask_ff[1] == $past(busReq.wdata[dac_status_pkg::BIT_CH2_UDR])
		&& mask_ff[0] == $past(busReq.wdata[dac_status_pkg::BIT_CH1_UDR]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_mask_hold;
		@(posedge clk) disable iff (!rst_n)
		!(busReq.wr && busReq.addr == dac_status_pkg::OFS_IRQ_MASK)
		|=> mask_ff == $past(mask_ff);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask changed unasked");

	// Flags keep their value unless set or cleared
	property p_ch2_hold;
		@(posedge clk) disable iff (!rst_n)
		ch2UnderrunFlag && !clr2
		|=> ch2UnderrunFlag;
	endproperty
	a_ch2_hold: assert property (p_ch2_hold) else $error("ch2 flag dropped");

	property p_ch1_hold;
		@(posedge clk) disable iff (!rst_n)
		ch1UnderrunFlag && !clr1
		|=> ch1UnderrunFlag;
	endproperty
	a_ch1_hold: assert property (p_ch1_hold) else $error("ch1 flag dropped");

	property p_ch2_quiet;
		@(posedge clk) disable iff (!rst_n)
		!ch2UnderrunFlag && !udrEvt.ch2
		|=> !ch2UnderrunFlag;
	endproperty
	a_ch2_quiet: assert property (p_ch2_quiet) else $error("ch2 flag set without event");

	property p_ch1_quiet;
		@(posedge clk) disable iff (!rst_n)
		!ch1UnderrunFlag && !udrEvt.ch1
		|=> !ch1UnderrunFlag;
	endproperty
	a_ch1_quiet: assert property (p_ch1_quiet) else $error("ch1 flag set without event");

	// An event in the clearing cycle must not be lost
	property p_ch2_set_wins;
		@(posedge clk) disable iff (!rst_n)
		udrEvt.ch2 && clr2
		|=> ch2UnderrunFlag;
	endproperty
	a_ch2_set_wins: assert property (p_ch2_set_wins) else $error("ch2 set lost");

	property p_ch1_set_wins;
		@(posedge clk) disable iff (!rst_n)
		udrEvt.ch1 && clr1
		|=> ch1UnderrunFlag;
	endproperty
	a_ch1_set_wins: assert property (p_ch1_set_wins) else $error("ch1 set lost");

	property p_ch1_zero_write;
		@(posedge clk) disable iff (!rst_n)
		wrStatus && !busReq.wdata[dac_status_pkg::BIT_CH1_UDR] && ch1UnderrunFlag
		|=> ch1UnderrunFlag;
	endproperty
	a_ch1_zero_write: assert property (p_ch1_zero_write) else $error("zero write cleared");

	// Writes to the read-only word views change nothing
	property p_ch2_output_ro;
		@(posedge clk) disable iff (!rst_n)
		busReq.wr && busReq.addr == dac_status_pkg::OFS_CH2_OUTPUT && ch2UnderrunFlag
		|=> ch2UnderrunFlag;
	endproperty
	a_ch2_output_ro: assert property (p_ch2_output_ro) else $error("ch2 view write acted");

	property p_ch1_output_ro;
		@(posedge clk) disable iff (!rst_n)
		busReq.wr && busReq.addr == dac_status_pkg::OFS_CH1_OUTPUT
		|=> mask_ff == $past(mask_ff);
	endproperty
	a_ch1_output_ro: assert property (p_ch1_output_ro) else $error("ch1 view write acted");

	c_udr2: cover property (@(posedge clk) disable iff (!rst_n) udrEvt.ch2 ##1 clr2);
	c_udr1: cover property (@(posedge clk) disable iff (!rst_n) udrEvt.ch1 && clr1);
	c_irq:  cover property (@(posedge clk) disable iff (!rst_n) irq ##1 !irq);
endmodule

/* File: verification/test_dac_output_and_underrun_status.sv */
`timescale 1ns/1ps
// Self-checking bench for the output views and underrun status registers
module test_dac_output_and_underrun_status;
	logic                      clk;
	logic                      rst_n;
	dac_status_pkg::bus_req_t  busReq;
	logic [31:0]               rdData;
	logic [11:0]               ch1Word;
	logic [11:0]               ch2Word;
	dac_status_pkg::udr_pair_t udrEvt;
	logic                      irq;
	int                        errorCnt;
	int                        checks;
	logic [31:0]               v;

	dac_output_status dut (
		.clk(clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
		.ch1OutputWord(ch1Word), .ch2OutputWord(ch2Word), .udrEvt(udrEvt), .irq(irq)
	);

	always #50 clk = ~clk;

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) busReq.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk) busReq.rd <= 1'b0;
		#1 d = rdData;
	endtask

	task automatic evt(input logic c2, input logic c1);
		@(posedge clk) udrEvt <= '{ch2: c2, ch1: c1};
		@(posedge clk) udrEvt <= '0;
	endtask

	task automatic t_reset;
		rd(8'h34, v); chk("status", v, 32'h0000_0000);
		rd(8'h38, v); chk("mask", v, 32'h0000_0000);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		$display("Test reset done");
	endtask

	task automatic t_words;
		ch1Word <= 12'hA5C;
		ch2Word <= 12'h3F1;
		wr(8'h2C, 32'hFFFF_FFFF);
		wr(8'h30, 32'hFFFF_FFFF);
		rd(8'h2C, v); chk("ch1 word", v, 32'h0000_0A5C);
		rd(8'h30, v); chk("ch2 word", v, 32'h0000_03F1);
		rd(8'h3C, v); chk("unmapped", v, 32'h0000_0000);
		$display("Test output words done");
	endtask

	task automatic t_flags;
		evt(1'b0, 1'b1);
		rd(8'h34, v); chk("flag ch1", v, 32'h0000_2000);
		evt(1'b1, 1'b0);
		wr(8'h34, 32'h0000_0000);
		wr(8'h34, 32'hDFFF_DFFF);
		rd(8'h34, v); chk("flags kept", v, 32'h2000_2000);
		wr(8'h34, 32'h0000_2000);
		rd(8'h34, v); chk("ch1 cleared", v, 32'h2000_0000);
		wr(8'h34, 32'h2000_0000);
		rd(8'h34, v); chk("ch2 cleared", v, 32'h0000_0000);
		$display("Test underrun flags done");
	endtask

	task automatic t_irq;
		evt(1'b1, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		wr(8'h38, 32'h2000_0000);
		repeat (2) @(posedge clk);
		#1 chk("irq raised", {31'h0, irq}, 32'h0000_0001);
		wr(8'h34, 32'h2000_0000);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
		$display("Test interrupt done");
	endtask

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		busReq = '0;
		ch1Word = 12'h000;
		ch2Word = 12'h000;
		udrEvt = '0;
		errorCnt = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_words();
		t_flags();
		t_irq();
		end_sim();
	end

	// The whole run needs well under 200 cycles
	initial begin
		repeat (2000) @(posedge clk);
		errorCnt++;
		end_sim();
	end
endmodule
